// ### rtl/tcc_timer.sv
// 8-bit timer/counter with one compare channel and AXI4-Lite registers
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`include "tcc_cfg.svh"
`default_nettype none
module tcc_timer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // timer tick from the prescaler / clock select path
  input wire logic timerTick,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt service from the core
  input wire tcc_pkg::tcc_ack_t irqAck,
  output logic compareIrq,
  output logic overflowIrq,
  // port pin
  input wire logic portValue,
  input wire logic outputPinDirection,
  output logic pinOut,
  output logic pinOe
);

  // registers visible to software
  tcc_pkg::tcc_ctrl_t timerControlA; // mode, output mode, enables, clock select
  logic [WIDTH-1:0] counterValue; // the count
  logic [WIDTH-1:0] compareValue; // active compare copy
  logic [WIDTH-1:0] compareBuffer; // software copy in pwm modes
  logic compareMatchFlag; // sticky match flag
  logic overflowFlag; // sticky overflow flag
  logic compareOutput; // internal output compare state
  logic countDown; // dual slope direction
  logic blockMatch; // armed by a counter write

  // bus handshake state; address and data may come in either
  // order, so each half is parked until its partner arrives
  logic awHeld; // write address parked
  logic wHeld; // write data parked
  logic [3:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;

  // decode helpers
  // both slopes count as pwm; only these modes buffer the compare
  function automatic logic isPwm(input logic [1:0] m);
    isPwm = (m == `TCC_MODE_PHASE) || (m == `TCC_MODE_FAST);
  endfunction : isPwm

  // output action for a non-pwm match, a force, or a pwm match under the toggle code
  // codes: 1 toggles, 2 clears, 3 sets, 0 leaves the state alone
  function automatic logic matchAction(input logic [1:0] om, input logic cur);
    case (om)
      2'h1: matchAction = ~cur;
      2'h2: matchAction = 1'b0;
      2'h3: matchAction = 1'b1;
      default: matchAction = cur;
    endcase
  endfunction : matchAction

  // write / read strobes
  // a register write lands on the edge that raises bvalid
  logic doWrite;
  logic doRead;
  logic wrCtrl;
  logic wrCount;
  logic wrCompare;
  logic wrFlags;
  logic tick; // effective timer clock edge
  logic pwm;
  logic match; // raw comparator equality
  logic matchEvent; // match not blocked, on a tick
  logic atTop;
  logic atBottom;
  logic forceCompare;
  logic [WIDTH-1:0] next_counterValue;
  logic next_countDown;

  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign doRead = s_axi_arvalid && !s_axi_rvalid;
  assign wrCtrl = doWrite && (awAddr == `TCC_ADDR_CTRL) && wStrb[0];
  assign wrCount = doWrite && (awAddr == `TCC_ADDR_COUNT) && wStrb[0];
  assign wrCompare = doWrite && (awAddr == `TCC_ADDR_COMPARE) && wStrb[0];
  assign wrFlags = doWrite && (awAddr == `TCC_ADDR_FLAGS) && wStrb[0];
  // stopped clock select gives no tick at all
  assign tick = clkEn && timerTick && (timerControlA.clockSelect != `TCC_CS_STOP);
  assign pwm = isPwm(timerControlA.modeSelect);
  assign match = (counterValue == compareValue);
  assign matchEvent = tick && match && !blockMatch;
  assign atTop = (counterValue == `TCC_MAX);
  assign atBottom = (counterValue == `TCC_BOTTOM);
  // force is ignored in pwm modes
  assign forceCompare = wrFlags && wData[`TCC_FLAG_FORCE] && !pwm;

  // axi ready outputs are simple combinational terms; they drop
  // while frozen, since a frozen block cannot park a request and
  // a handshake taken then would be lost
  assign s_axi_awready = clkEn && !awHeld;
  assign s_axi_wready = clkEn && !wHeld;
  assign s_axi_arready = clkEn && !s_axi_rvalid;
  assign compareIrq = compareMatchFlag && timerControlA.compareIrqEnable;
  assign overflowIrq = overflowFlag && timerControlA.overflowIrqEnable;
  // override only when an output mode bit is set; direction stays with the port
  assign pinOut = (timerControlA.outputMode != 2'h0) ? compareOutput : portValue;
  assign pinOe = outputPinDirection;

  // next count: mode decides the sequence, output mode never does;
  // only a proposal, the counter process picks tick or software
  // write for this cycle
  always_comb begin
    next_counterValue = counterValue;
    next_countDown = countDown;
    case (timerControlA.modeSelect)
      `TCC_MODE_NORMAL: begin
        next_counterValue = counterValue + 1'b1;
        next_countDown = 1'b0;
      end
      `TCC_MODE_CTC: begin
        // clear at the compare value, which becomes top
        next_counterValue = match ? `TCC_BOTTOM : counterValue + 1'b1;
        next_countDown = 1'b0;
      end
      `TCC_MODE_FAST: begin
        next_counterValue = atTop ? `TCC_BOTTOM : counterValue + 1'b1;
        next_countDown = 1'b0;
      end
      `TCC_MODE_PHASE: begin
        // turn at max and bottom, each held one tick
        if (!countDown && atTop) begin
          next_countDown = 1'b1;
          next_counterValue = counterValue - 1'b1;
        end else if (countDown && atBottom) begin
          next_countDown = 1'b0;
          next_counterValue = counterValue + 1'b1;
        end else begin
          next_counterValue = countDown ? counterValue - 1'b1 : counterValue + 1'b1;
        end
      end
      default: begin
        next_counterValue = counterValue;
      end
    endcase
  end

  // counter: software write wins over any tick
  // direction is left alone on a write, so a dual slope sweep
  // carries on the way it was heading
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      counterValue <= `TCC_BOTTOM;
      countDown <= 1'b0;
    end else if (clkEn) begin
      if (wrCount) begin
        counterValue <= wData[WIDTH-1:0];
      end else if (tick) begin
        counterValue <= next_counterValue;
        countDown <= next_countDown;
      end
    end
  end

  // match blocking armed by counter write, spent on next tick
  // stays armed while stopped, so the first tick after a restart
  // is still blocked
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blockMatch <= 1'b0;
    end else if (clkEn) begin
      if (wrCount) begin
        blockMatch <= 1'b1;
      end else if (tick) begin
        blockMatch <= 1'b0;
      end
    end
  end

  // control register
  // all fields land at once; a mode change leaves the output state
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timerControlA <= '0;
    end else if (clkEn && wrCtrl) begin
      // output mode takes effect at once, no buffering
      timerControlA <= wData[8:0];
    end
  end

  // compare value: buffered in pwm modes, direct otherwise
  // a write in the reload cycle waits for the next top, which
  // keeps every pwm period whole
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compareValue <= `TCC_BOTTOM;
      compareBuffer <= `TCC_BOTTOM;
    end else if (clkEn) begin
      if (wrCompare) begin
        compareBuffer <= wData[WIDTH-1:0];
      end
      if (!pwm) begin
        // bypass: write lands straight in the active copy
        if (wrCompare) begin
          compareValue <= wData[WIDTH-1:0];
        end
      end else if (tick) begin
        // phase mode reloads at max, fast mode at bottom (after max)
        if (atTop) begin
          compareValue <= compareBuffer;
        end
      end
    end
  end

  // compare match flag: set beats clear in the same cycle
  // service and software clear are equivalent, either is enough
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compareMatchFlag <= 1'b0;
    end else if (clkEn) begin
      if (matchEvent) begin
        compareMatchFlag <= 1'b1;
      end else if (irqAck.compareAck) begin
        compareMatchFlag <= 1'b0;
      end else if (wrFlags && wData[`TCC_FLAG_CMP]) begin
        compareMatchFlag <= 1'b0;
      end
    end
  end

  // overflow flag: normal on wrap to zero, ctc and fast on a tick at max, phase at bottom
  // a counter write in the same cycle suppresses it, since the
  // count that would have wrapped never happens
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflowFlag <= 1'b0;
    end else if (clkEn) begin
      if (tick && !wrCount && (((timerControlA.modeSelect == `TCC_MODE_PHASE) && atBottom)
          || ((timerControlA.modeSelect != `TCC_MODE_PHASE) && atTop))) begin
        overflowFlag <= 1'b1;
      end else if (irqAck.overflowAck) begin
        overflowFlag <= 1'b0;
      end else if (wrFlags && wData[`TCC_FLAG_OVF]) begin
        overflowFlag <= 1'b0;
      end
    end
  end

  // output compare state; untouched by mode changes
  // force is dropped in pwm modes, where it would break the
  // period of the waveform
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compareOutput <= 1'b0;
    end else if (clkEn) begin
      if (timerControlA.outputMode == 2'h0) begin
        compareOutput <= compareOutput;
      end else if (forceCompare) begin
        compareOutput <= matchAction(timerControlA.outputMode, compareOutput);
      end else if (!pwm && matchEvent) begin
        compareOutput <= matchAction(timerControlA.outputMode, compareOutput);
      end else if (pwm && timerControlA.outputMode[1]) begin
        // mode 2 non-inverted, mode 3 inverted; toggle code falls through and toggles on a match
        if (matchEvent) begin
          if (timerControlA.modeSelect == `TCC_MODE_FAST || !countDown) begin
            compareOutput <= timerControlA.outputMode[0];
          end else begin
            compareOutput <= ~timerControlA.outputMode[0];
          end
        end else if (tick && atTop && timerControlA.modeSelect == `TCC_MODE_FAST) begin
          compareOutput <= ~timerControlA.outputMode[0];
        end
      end else if (pwm && matchEvent) begin
        compareOutput <= matchAction(timerControlA.outputMode, compareOutput);
      end
    end
  end

  // write address / data capture, either order
  // one half waits here while the other half is late
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 4'h0;
      wData <= 32'h0;
      wStrb <= 4'h0;
    end else if (clkEn) begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // write response; unmapped address answers slverr
  // held until taken; no new write lands meanwhile
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCC_RESP_OKAY;
    end else if (clkEn) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr > `TCC_ADDR_FLAGS || awAddr[1:0] != 2'h0)
          ? `TCC_RESP_SLVERR : `TCC_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data; compare reads buffer in pwm modes
  // one read at a time: arready stays low until rready
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `TCC_RESP_OKAY;
    end else if (clkEn) begin
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `TCC_RESP_OKAY;
        case (s_axi_araddr)
          `TCC_ADDR_CTRL: s_axi_rdata <= {23'h0, timerControlA};
          `TCC_ADDR_COUNT: s_axi_rdata <= {24'h0, counterValue};
          `TCC_ADDR_COMPARE: begin
            s_axi_rdata <= {24'h0, pwm ? compareBuffer : compareValue};
          end
          `TCC_ADDR_FLAGS: s_axi_rdata <= {29'h0, compareOutput, compareMatchFlag, overflowFlag};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `TCC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : tcc_timer
`default_nettype wire

// ### rtl/tcc_cfg.svh
// constants for the 8-bit timer/counter compare core
// Function
// - counter clears, increments or decrements per tick
// - clock select zero stops the counter
// - counter readable and writable at any time
// - software counter write beats hardware update
// - mode select sets sequence, output mode not
// - equality sets match flag next tick
// - enabled flag requests interrupt, service clears
// - writing one clears match flag
// - compare value double buffered in PWM modes
// - software reaches buffer when buffering active
// - force strobe acts like match, no flag; ignored in PWM modes
// - counter write blocks match next tick
// - output state kept across mode change
// - output mode unbuffered, acts next match
// - nonzero output mode overrides port value
// - output mode zero leaves output state
// - output mode picks set/clear/toggle or polarity
// - normal mode counts up, wraps ff to 00
// - normal mode overflow flag set at zero
// - overflow flag interrupts, service clears
// - mode two clears counter at compare value
// - mode three single slope to ff
// - mode one dual slope up and down
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
`define TCC_ADDR_CTRL 4'h0
`define TCC_ADDR_COUNT 4'h4
`define TCC_ADDR_COMPARE 4'h8
`define TCC_ADDR_FLAGS 4'hc
`define TCC_MODE_NORMAL 2'h0
`define TCC_MODE_PHASE 2'h1
`define TCC_MODE_CTC 2'h2
`define TCC_MODE_FAST 2'h3
`define TCC_CS_STOP 3'h0
`define TCC_BOTTOM 8'h00
`define TCC_MAX 8'hff
`define TCC_FLAG_OVF 0
`define TCC_FLAG_CMP 1
`define TCC_FLAG_FORCE 2
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2
`endif

// ### rtl/tcc_pkg.sv
// types shared by the timer/counter compare core
`default_nettype none
package tcc_pkg;
  // control register image
  typedef struct packed {
    logic [1:0] outputMode;
    logic [1:0] modeSelect;
    logic compareIrqEnable;
    logic overflowIrqEnable;
    logic [2:0] clockSelect;
  } tcc_ctrl_t;
  // interrupt service acknowledges from the core
  typedef struct packed {
    logic compareAck;
    logic overflowAck;
  } tcc_ack_t;
endpackage : tcc_pkg
`default_nettype wire

// ### tb/tcc_timer_checker.sv
// port-level assertions for the timer/counter compare core
`default_nettype none
module tcc_timer_checker (
  // clock, reset and tick
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic timerTick,
  // bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // interrupts and pin
  input wire tcc_pkg::tcc_ack_t irqAck,
  input wire logic compareIrq,
  input wire logic overflowIrq,
  input wire logic outputPinDirection,
  input wire logic pinOe
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // the timer never owns the pin direction
  a_oe_follows_dir: assert property (pinOe == outputPinDirection)
    else $error("pin enable differs from port direction");
  // read answer one edge after the address is taken, then stands
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clkEn |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data withdrawn before taken");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn before taken");
  // service acknowledge clears the flag when no tick can set it again
  a_cmp_ack_clears: assert property (
    clkEn && irqAck.compareAck && !timerTick |=> !compareIrq)
    else $error("compare request survives service");
  a_ovf_ack_clears: assert property (
    clkEn && irqAck.overflowAck && !timerTick |=> !overflowIrq)
    else $error("overflow request survives service");
  // a frozen block keeps its requests
  a_frozen_irq: assert property (!clkEn |=> $stable(compareIrq) && $stable(overflowIrq))
    else $error("request changed while frozen");
  // without a tick only a register write may raise a request
  a_no_tick_flag: assert property (
    clkEn && !timerTick ##1 ($rose(compareIrq) || $rose(overflowIrq)) |-> $rose(s_axi_bvalid))
    else $error("request raised without a tick");
endmodule : tcc_timer_checker
`default_nettype wire

// ### tb/tcc_irq_svc.sv
// interrupt service model standing in for the processor core
`default_nettype none
module tcc_irq_svc (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // service control from the bench
  input wire logic svcEn,
  input wire logic [3:0] svcDelay,
  // requests in, acknowledges out
  input wire logic compareIrq,
  input wire logic overflowIrq,
  output var tcc_pkg::tcc_ack_t irqAck
);
  logic [3:0] waitCnt; // cycles waited before servicing
  // one pulse per service, compare first; waiting for the
  // previous pulse to land avoids servicing one flag twice
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitCnt <= 4'h0;
      irqAck <= '0;
    end else begin
      irqAck <= '0;
      if (!svcEn || irqAck != '0 || !(compareIrq || overflowIrq)) begin
        waitCnt <= 4'h0;
      end else if (waitCnt == svcDelay) begin
        waitCnt <= 4'h0;
        irqAck.compareAck <= compareIrq;
        irqAck.overflowAck <= !compareIrq;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule : tcc_irq_svc
`default_nettype wire

// ### tb/tcc_timer_tb.sv
// self-checking bench for the timer/counter compare core
`include "tcc_cfg.svh"
`default_nettype none
module tcc_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // design stimulus and observation
  logic sys_clk, sys_rst, clkEn, timerTick, portValue, outputPinDirection, svcEn;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, compareIrq, overflowIrq;
  logic pinOut, pinOe;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, svcDelay;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  tcc_pkg::tcc_ack_t irqAck; // from the service model
  int failures, cmp_count;
  tcc_timer tcc_timer_inst (.sys_clk, .sys_rst, .clkEn, .timerTick, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irqAck, .compareIrq,
    .overflowIrq, .portValue, .outputPinDirection, .pinOut, .pinOe);
  tcc_irq_svc tcc_irq_svc_inst (.sys_clk, .sys_rst, .svcEn, .svcDelay, .compareIrq,
    .overflowIrq, .irqAck);
  // verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic tmo();
    failures++;
    $display("ERROR bus wait expected answer seen none");
    end_sim();
  endtask : tmo
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  // control word from its fields
  function automatic logic [31:0] ctl(input logic [1:0] om, input logic [1:0] md,
                                      input logic [2:0] cs, input logic ie = 1'b0);
    tcc_pkg::tcc_ctrl_t c;
    c = '{outputMode: om, modeSelect: md, compareIrqEnable: ie, overflowIrqEnable: ie,
          clockSelect: cs};
    return {23'h0, c};
  endfunction : ctl
  // one write; tick held at tk, response accepted late on purpose
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic tk = 1'b0);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    timerTick <= tk;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == 3) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
    if (n >= 40) tmo();
    chk("write response", `TCC_RESP_OKAY, s_axi_bresp);
    s_axi_bready <= 1'b0;
    timerTick <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == 2) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
    if (n >= 40) tmo();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  // read and compare the bits under mask m
  task automatic rc(input string w, input logic [3:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(w, e & m, d & m);
  endtask : rc
  // n timer ticks, one every second cycle
  task automatic tk(input int n);
    repeat (n) begin
      timerTick <= 1'b1;
      @(posedge sys_clk);
      timerTick <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : tk
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rc("control", `TCC_ADDR_CTRL, 32'h0);
    rc("counter", `TCC_ADDR_COUNT, 32'h0);
    rc("compare", `TCC_ADDR_COMPARE, 32'h0);
    rc("flags", `TCC_ADDR_FLAGS, 32'h0);
    rd(4'h2, d, r);
    chk("unaligned response", `TCC_RESP_SLVERR, r);
    chk("unaligned data", 32'h0, d);
  endtask : t_reset
  task automatic t_normal();
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_MODE_NORMAL, 3'h1));
    wr(`TCC_ADDR_COUNT, 32'hfe);
    tk(2);
    rc("wrap", `TCC_ADDR_COUNT, 32'h0);
    rc("overflow set", `TCC_ADDR_FLAGS, 32'h1, 32'h3);
    wr(`TCC_ADDR_FLAGS, 32'h1);
    rc("overflow clear", `TCC_ADDR_FLAGS, 32'h0, 32'h1);
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_MODE_NORMAL, `TCC_CS_STOP));
    tk(3);
    rc("stopped", `TCC_ADDR_COUNT, 32'h0);
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_MODE_NORMAL, 3'h1));
    clkEn <= 1'b0;
    tk(3);
    clkEn <= 1'b1;
    tk(1);
    rc("frozen then count", `TCC_ADDR_COUNT, 32'h1);
    rc("match at zero", `TCC_ADDR_FLAGS, 32'h2, 32'h2);
  endtask : t_normal
  task automatic t_match();
    wr(`TCC_ADDR_FLAGS, 32'h3);
    wr(`TCC_ADDR_COMPARE, 32'h5);
    wr(`TCC_ADDR_COUNT, 32'h4);
    tk(1);
    rc("no match yet", `TCC_ADDR_FLAGS, 32'h0, 32'h2);
    tk(1);
    rc("match flag", `TCC_ADDR_FLAGS, 32'h2, 32'h2);
    wr(`TCC_ADDR_FLAGS, 32'h0);
    rc("zero write keeps", `TCC_ADDR_FLAGS, 32'h2, 32'h2);
    wr(`TCC_ADDR_FLAGS, 32'h2);
    rc("one write clears", `TCC_ADDR_FLAGS, 32'h0, 32'h2);
    wr(`TCC_ADDR_COMPARE, 32'h40);
    wr(`TCC_ADDR_COUNT, 32'h40, 1'b1);
    rc("write beats tick", `TCC_ADDR_COUNT, 32'h42);
    rc("match blocked", `TCC_ADDR_FLAGS, 32'h0, 32'h2);
  endtask : t_match
  task automatic t_modes();
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_MODE_CTC, 3'h1));
    wr(`TCC_ADDR_COMPARE, 32'h3);
    wr(`TCC_ADDR_COUNT, 32'h0);
    tk(4);
    rc("clear at compare", `TCC_ADDR_COUNT, 32'h0);
    rc("ctc match", `TCC_ADDR_FLAGS, 32'h2, 32'h2);
    wr(`TCC_ADDR_FLAGS, 32'h3);
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_MODE_FAST, 3'h1));
    wr(`TCC_ADDR_COMPARE, 32'h10);
    rc("buffer read", `TCC_ADDR_COMPARE, 32'h10);
    wr(`TCC_ADDR_COUNT, 32'h0e);
    tk(3);
    rc("old value active", `TCC_ADDR_FLAGS, 32'h0, 32'h2);
    wr(`TCC_ADDR_COUNT, 32'hfe);
    tk(2);
    rc("fast restart", `TCC_ADDR_COUNT, 32'h0);
    tk(17);
    rc("new value active", `TCC_ADDR_FLAGS, 32'h2, 32'h2);
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_MODE_PHASE, 3'h1));
    wr(`TCC_ADDR_COUNT, 32'hfe);
    tk(3);
    rc("turn at max", `TCC_ADDR_COUNT, 32'hfd);
  endtask : t_modes
  task automatic t_force();
    logic [1:0] om[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic ex[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr(`TCC_ADDR_FLAGS, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(`TCC_ADDR_CTRL, ctl(om[i], `TCC_MODE_NORMAL, `TCC_CS_STOP));
      wr(`TCC_ADDR_FLAGS, 32'h4);
      rc("forced", `TCC_ADDR_FLAGS, {29'h0, ex[i], 2'h0}, 32'h6);
      chk("pin value", (om[i] != 2'h0) ? ex[i] : portValue, pinOut);
    end
    outputPinDirection <= 1'b1;
    @(posedge sys_clk);
    chk("pin enable", 32'h1, pinOe);
    wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_MODE_FAST, `TCC_CS_STOP));
    rc("state kept", `TCC_ADDR_FLAGS, 32'h4, 32'h4);
    // non-inverted fast pwm: clear at the match, set again at bottom
    wr(`TCC_ADDR_CTRL, ctl(2'h2, `TCC_MODE_FAST, 3'h1));
    wr(`TCC_ADDR_COUNT, 32'h0f);
    tk(2);
    rc("pwm clear at match", `TCC_ADDR_FLAGS, 32'h0, 32'h4);
    wr(`TCC_ADDR_COUNT, 32'hff);
    tk(1);
    rc("pwm set at bottom", `TCC_ADDR_FLAGS, 32'h4, 32'h4);
    chk("pwm pin", 32'h1, pinOut);
  endtask : t_force
  // flags raised, then serviced promptly and slowly by the model
  task automatic t_irq();
    for (int i = 0; i < 2; i++) begin
      wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_MODE_NORMAL, 3'h1));
      wr(`TCC_ADDR_COMPARE, 32'h0);
      wr(`TCC_ADDR_COUNT, 32'hff);
      tk(2);
      wr(`TCC_ADDR_CTRL, ctl(2'h0, `TCC_MODE_NORMAL, 3'h1, 1'b1));
      chk("compare request", 32'h1, compareIrq);
      chk("overflow request", 32'h1, overflowIrq);
      svcDelay <= 4'(3 * i);
      svcEn <= 1'b1;
      repeat (20) @(posedge sys_clk);
      svcEn <= 1'b0;
      rc("serviced", `TCC_ADDR_FLAGS, 32'h0, 32'h3);
    end
  endtask : t_irq
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    $display("ERROR run length expected end seen limit");
    end_sim();
  end
  initial begin
    {failures, cmp_count} = '0;
    {sys_rst, clkEn, s_axi_wstrb} = {1'b1, 1'b1, 4'hf};
    {timerTick, portValue, outputPinDirection, svcEn, svcDelay} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_normal();
    t_match();
    t_modes();
    t_force();
    t_irq();
    end_sim();
  end
endmodule : tcc_timer_tb
bind tcc_timer tcc_timer_checker tcc_timer_checker_inst (.sys_clk, .sys_rst, .clkEn,
  .timerTick, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
  .s_axi_bready, .irqAck, .compareIrq, .overflowIrq, .outputPinDirection, .pinOe);
`default_nettype wire
